// File: verilog/sorm_defs.svh
// Constants for the synthesizer output and reference monitor control block.
// Assumes a 200 MHz system clock and an APB bus with 32-bit data.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef SORM_DEFS_SVH
`define SORM_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SORM_CLK_PERIOD_NS 5
`define SORM_SYNC_MIN_US 50
`define SORM_SYNC_MAX_US 300
`define SORM_SYNC_CYCLES ((`SORM_SYNC_MIN_US * 1000 + `SORM_CLK_PERIOD_NS - 1) / `SORM_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SORM_OFF_CTRL 12'h000
`define SORM_OFF_STATUS 12'h004
`define SORM_OFF_FB_WHOLE 12'h008
`define SORM_OFF_FB_FRAC 12'h00C
`define SORM_OFF_FREQ_WORD 12'h010
`define SORM_OFF_OUT_EN 12'h014
`define SORM_OFF_OUT_MODE 12'h018
`define SORM_OFF_OUT_RATIO 12'h01C
`define SORM_OFF_MON_BASE 12'h020
`define SORM_OFF_MON_STRIDE 12'h010
`define SORM_OFF_MON_NOM 12'h000
`define SORM_OFF_MON_MARGIN 12'h004
`define SORM_OFF_MON_TIMES 12'h008

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define SORM_CTRL_DCO 0
`define SORM_CTRL_OE_SEL 1
`define SORM_CTRL_STARTUP 2
`define SORM_CTRL_SYNC 3
`define SORM_ST_CAL_DONE 0
`define SORM_ST_CAL_FAIL 1
`define SORM_ST_LOCK 2
`define SORM_ST_LOL_EVT 3
`define SORM_ST_LOS_STS 4
`define SORM_ST_LOS_EVT 6
`define SORM_ST_STATE 8
`define SORM_WHOLE_W 9
`define SORM_FRAC_W 27
`define SORM_NUM_OUT 4
`define SORM_NUM_MON 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SORM_RST_CTRL 4'h4
`define SORM_RST_RATIO 32'h0404_0404

`endif

// File: verilog/sorm_pkg.sv
// Types shared by the synthesizer output and reference monitor control block.
// Assumes the constants header is compiled alongside.
package sorm_pkg;

  // Start-up and divider synchronisation sequence, Gray coded except the SORM_SYNC to SORM_RUN step.
  typedef enum logic [2:0] {
    SORM_PWR = 3'b000,
    SORM_DIS = 3'b001,
    SORM_SYNC = 3'b011,
    SORM_LOCKW = 3'b010,
    SORM_RUN = 3'b110,
    SORM_RESYNC = 3'b111
  } sorm_state_e;

  // Pin level chosen for a disabled output.
  typedef enum logic [1:0] {
    SORM_DIS_LOW = 2'b00,
    SORM_DIS_HIGH = 2'b01,
    SORM_DIS_HIZ = 2'b10
  } sorm_dis_e;

endpackage

// File: verilog/sorm_ctrl.sv
// Control logic of the synthesizer: feedback word, output gating, monitors.
// Assumes APB from a host on ref_clk_i; status and pin inputs are asynchronous.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "sorm_defs.svh"

module sorm_ctrl
  import sorm_pkg::*;
#(
  parameter int SYNC_CYCLES = `SORM_SYNC_CYCLES
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Analog and pin status, asynchronous
  input wire logic supplies_stable_i,
  input wire logic bias_cal_done_i,
  input wire logic bias_cal_fail_i,
  input wire logic config_loaded_i,
  input wire logic pll_lock_i,
  input wire logic output_enable_pin_i,
  input wire logic [1:0] ref_in_i,
  // Feedback divider settings
  output logic [8:0] feedback_ratio_whole_o,
  output logic [26:0] feedback_ratio_fraction_o,
  output logic [31:0] feedback_adjust_o,
  // Clock output pins
  output logic [3:0] out_true_o,
  output logic [3:0] out_true_oe_o,
  output logic [3:0] out_comp_o,
  output logic [3:0] out_comp_oe_o,
  // Monitor status
  output logic [1:0] los_status_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic [7:0] last_reg;
  logic [7:0] async_in;
  assign async_in = {ref_in_i, output_enable_pin_i, pll_lock_i, config_loaded_i,
                     bias_cal_fail_i, bias_cal_done_i, supplies_stable_i};

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      last_reg <= 8'h00;
    end else if (clk_en_i) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  logic supplies_s;
  logic cal_done_s;
  logic cal_fail_s;
  logic cfg_s;
  logic lock_s;
  logic oe_pin_s;
  assign supplies_s = sync_reg[0];
  assign cal_done_s = sync_reg[1];
  assign cal_fail_s = sync_reg[2];
  assign cfg_s = sync_reg[3];
  assign lock_s = sync_reg[4];
  assign oe_pin_s = sync_reg[5];

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [3:0] ctrl_reg, ctrl_next;
  logic [8:0] whole_reg, whole_next;
  logic [26:0] frac_reg, frac_next;
  logic [31:0] word_reg, word_next;
  logic [7:0] out_en_reg, out_en_next;
  logic [15:0] out_mode_reg, out_mode_next;
  logic [31:0] ratio_reg, ratio_next;
  logic [15:0] nom_reg [2];
  logic [15:0] nom_next [2];
  logic [31:0] margin_reg [2];
  logic [31:0] margin_next [2];
  logic [15:0] times_reg [2];
  logic [15:0] times_next [2];
  logic cal_done_reg, cal_done_next;
  logic cal_fail_reg, cal_fail_next;
  logic lol_reg, lol_next;
  logic [31:0] rdata_reg, rdata_next;
  logic sync_cmd;
  logic [1:0] los_sts;
  logic [1:0] los_evt;
  logic [1:0] evt_clr;
  sorm_state_e state_reg, state_next;

  logic wr_en;
  logic addr_ok;
  assign wr_en = psel_i & penable_i & pwrite_i & clk_en_i;
  // The bus stalls while the block is frozen, so no write is lost.
  assign pready_o = clk_en_i;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o = rdata_reg;

  always_comb begin
    addr_ok = 1'b0;
    case (paddr_i)
      `SORM_OFF_CTRL, `SORM_OFF_STATUS, `SORM_OFF_FB_WHOLE, `SORM_OFF_FB_FRAC,
      `SORM_OFF_FREQ_WORD, `SORM_OFF_OUT_EN, `SORM_OFF_OUT_MODE,
      `SORM_OFF_OUT_RATIO: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
    for (int m = 0; m < `SORM_NUM_MON; m++) begin
      if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_NOM) ||
          paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_MARGIN) ||
          paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_TIMES)) begin
        addr_ok = 1'b1;
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next[`SORM_CTRL_SYNC] = 1'b0;
    whole_next = whole_reg;
    frac_next = frac_reg;
    word_next = word_reg;
    out_en_next = out_en_reg;
    out_mode_next = out_mode_reg;
    ratio_next = ratio_reg;
    nom_next = nom_reg;
    margin_next = margin_reg;
    times_next = times_reg;
    evt_clr = 2'b00;
    cal_done_next = cal_done_reg | cal_done_s;
    cal_fail_next = cal_fail_reg | cal_fail_s;
    lol_next = lol_reg;
    if (wr_en && paddr_i == `SORM_OFF_STATUS && pwdata_i[`SORM_ST_LOL_EVT]) begin
      lol_next = 1'b0;
    end
    // lock falling edge, set beats clear
    if (last_reg[4] && !lock_s) begin
      lol_next = 1'b1;
    end
    if (wr_en) begin
      case (paddr_i)
        `SORM_OFF_CTRL: ctrl_next = pwdata_i[3:0];
        `SORM_OFF_STATUS: evt_clr = pwdata_i[`SORM_ST_LOS_EVT +: 2];
        `SORM_OFF_FB_WHOLE: whole_next = pwdata_i[8:0];
        `SORM_OFF_FB_FRAC: frac_next = pwdata_i[26:0];
        `SORM_OFF_FREQ_WORD: word_next = pwdata_i;
        `SORM_OFF_OUT_EN: out_en_next = pwdata_i[7:0];
        `SORM_OFF_OUT_MODE: out_mode_next = pwdata_i[15:0];
        `SORM_OFF_OUT_RATIO: ratio_next = pwdata_i;
        default: ;
      endcase
      for (int m = 0; m < `SORM_NUM_MON; m++) begin
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_NOM)) begin
          nom_next[m] = pwdata_i[15:0];
        end
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_MARGIN)) begin
          margin_next[m] = pwdata_i;
        end
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_TIMES)) begin
          times_next[m] = pwdata_i[15:0];
        end
      end
    end
    rdata_next = rdata_reg;
    if (psel_i && !penable_i) begin
      rdata_next = 32'h0000_0000;
      case (paddr_i)
        `SORM_OFF_CTRL: rdata_next[2:0] = ctrl_reg[2:0];
        `SORM_OFF_STATUS: rdata_next[10:0] = {state_reg, los_evt, los_sts, lol_reg,
                                               lock_s, cal_fail_reg, cal_done_reg};
        `SORM_OFF_FB_WHOLE: rdata_next[8:0] = whole_reg;
        `SORM_OFF_FB_FRAC: rdata_next[26:0] = frac_reg;
        `SORM_OFF_FREQ_WORD: rdata_next = word_reg;
        `SORM_OFF_OUT_EN: rdata_next[7:0] = out_en_reg;
        `SORM_OFF_OUT_MODE: rdata_next[15:0] = out_mode_reg;
        `SORM_OFF_OUT_RATIO: rdata_next = ratio_reg;
        default: ;
      endcase
      for (int m = 0; m < `SORM_NUM_MON; m++) begin
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_NOM)) begin
          rdata_next[15:0] = nom_reg[m];
        end
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_MARGIN)) begin
          rdata_next = margin_reg[m];
        end
        if (paddr_i == 12'(`SORM_OFF_MON_BASE + m * `SORM_OFF_MON_STRIDE + `SORM_OFF_MON_TIMES)) begin
          rdata_next[15:0] = times_reg[m];
        end
      end
    end
  end

  assign sync_cmd = ctrl_reg[`SORM_CTRL_SYNC];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `SORM_RST_CTRL;
      whole_reg <= 9'h000;
      frac_reg <= 27'h000_0000;
      word_reg <= 32'h0000_0000;
      out_en_reg <= 8'h00;
      out_mode_reg <= 16'h0000;
      ratio_reg <= `SORM_RST_RATIO;
      nom_reg <= '{default: 16'h0000};
      margin_reg <= '{default: 32'h0000_0000};
      times_reg <= '{default: 16'h0000};
      cal_done_reg <= 1'b0;
      cal_fail_reg <= 1'b0;
      lol_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en_i) begin
      ctrl_reg <= ctrl_next;
      whole_reg <= whole_next;
      frac_reg <= frac_next;
      word_reg <= word_next;
      out_en_reg <= out_en_next;
      out_mode_reg <= out_mode_next;
      ratio_reg <= ratio_next;
      nom_reg <= nom_next;
      margin_reg <= margin_next;
      times_reg <= times_next;
      cal_done_reg <= cal_done_next;
      cal_fail_reg <= cal_fail_next;
      lol_reg <= lol_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Feedback word
  // ----------------------------------------------------------------------
  logic signed [68:0] scaled;
  logic [31:0] adjust_reg, adjust_next;
  // ratio is whole plus fraction over 2^27
  assign scaled = $signed(word_reg) * $signed({1'b0, whole_reg, frac_reg});

  always_comb begin
    adjust_next = ctrl_reg[`SORM_CTRL_DCO] ? scaled[58:27] : word_reg;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adjust_reg <= 32'h0000_0000;
    end else if (clk_en_i) begin
      adjust_reg <= adjust_next;
    end
  end

  assign feedback_ratio_whole_o = whole_reg;
  assign feedback_ratio_fraction_o = frac_reg;
  assign feedback_adjust_o = adjust_reg;

  // ----------------------------------------------------------------------
  // Start-up sequence and divider synchronisation
  // ----------------------------------------------------------------------
  logic [15:0] hold_cnt_reg, hold_cnt_next;

  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (state_reg)
      SORM_PWR: if (supplies_s) state_next = SORM_DIS;
      SORM_DIS: begin
        if (cfg_s) begin
          state_next = SORM_SYNC;
          hold_cnt_next = 16'(SYNC_CYCLES);
        end
      end
      SORM_SYNC: begin
        // clocks stopped for the hold time
        hold_cnt_next = hold_cnt_reg - 16'h0001;
        if (hold_cnt_reg <= 16'h0001) begin
          state_next = ctrl_reg[`SORM_CTRL_STARTUP] ? SORM_LOCKW : SORM_RUN;
        end
      end
      SORM_LOCKW: if (lock_s) state_next = SORM_RUN;
      SORM_RUN: begin
        if (sync_cmd) begin
          state_next = SORM_RESYNC;
          hold_cnt_next = 16'(SYNC_CYCLES);
        end
      end
      SORM_RESYNC: begin
        hold_cnt_next = hold_cnt_reg - 16'h0001;
        if (hold_cnt_reg <= 16'h0001) state_next = SORM_RUN;
      end
      default: state_next = SORM_PWR;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= SORM_PWR;
      hold_cnt_reg <= 16'h0000;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  logic powered;
  logic hold_div;
  logic run_ok;
  assign powered = (state_reg != SORM_PWR);
  assign hold_div = (state_reg != SORM_RUN) && (state_reg != SORM_LOCKW);
  // Lock no longer matters once running.
  assign run_ok = (state_reg == SORM_RUN) || (state_reg == SORM_RESYNC);

  // ----------------------------------------------------------------------
  // Output dividers and drivers
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `SORM_NUM_OUT; i++) begin : g_out
    logic [7:0] cnt_reg, cnt_next;
    logic en_reg, en_next;
    logic p_reg, p_next, n_reg, n_next, oe_reg, oe_next;
    logic [7:0] div;
    logic want;
    logic clk;
    logic pd;
    assign pd = out_en_reg[4 + i];
    assign div = (ratio_reg[i*8 +: 8] < 8'h02) ? 8'h02 : ratio_reg[i*8 +: 8];
    assign clk = ~hold_div & (cnt_reg < {1'b0, div[7:1]});
    assign want = run_ok & ~out_en_reg[i] & (ctrl_reg[`SORM_CTRL_OE_SEL] | oe_pin_s);

    always_comb begin
      cnt_next = (hold_div || cnt_reg >= div - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
      en_next = en_reg;
      if (pd || !powered) begin
        en_next = 1'b0;
      // change only at end of low phase
      end else if (hold_div || cnt_reg >= div - 8'h01) begin
        en_next = want;
      end
      p_next = 1'b0;
      n_next = 1'b0;
      oe_next = 1'b0;
      if (!pd && powered) begin
        oe_next = 1'b1;
        if (en_reg) begin
          case (out_mode_reg[i*4+2 +: 2])
            2'b00: begin p_next = clk; n_next = ~clk; end
            2'b01: p_next = clk;
            2'b10: n_next = clk;
            default: begin p_next = clk; n_next = clk; end
          endcase
        end else begin
          case (sorm_dis_e'(out_mode_reg[i*4 +: 2]))
            SORM_DIS_LOW: oe_next = 1'b1;
            SORM_DIS_HIGH: begin p_next = 1'b1; n_next = 1'b1; end
            default: oe_next = 1'b0;
          endcase
        end
      end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cnt_reg <= 8'h00;
        en_reg <= 1'b0;
        p_reg <= 1'b0;
        n_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (clk_en_i) begin
        cnt_reg <= cnt_next;
        en_reg <= en_next;
        p_reg <= p_next;
        n_reg <= n_next;
        oe_reg <= oe_next;
      end
    end

    assign out_true_o[i] = p_reg;
    assign out_comp_o[i] = n_reg;
    assign out_true_oe_o[i] = oe_reg;
    assign out_comp_oe_o[i] = oe_reg;
  end

  // ----------------------------------------------------------------------
  // Loss-of-signal monitors
  // ----------------------------------------------------------------------
  for (genvar m = 0; m < `SORM_NUM_MON; m++) begin : g_mon
    logic [15:0] mc_reg, mc_next;
    logic [7:0] good_reg, good_next, fail_reg, fail_next;
    logic sts_reg, sts_next, evt_reg, evt_next;
    logic edge_seen, timeout, eval;
    logic [15:0] diff;
    logic [15:0] acc, rej;
    assign acc = margin_reg[m][15:0];
    assign rej = margin_reg[m][31:16];
    assign edge_seen = sync_reg[6 + m] & ~last_reg[6 + m];
    // A missing edge still ends the window, so a dead reference fails.
    assign timeout = {1'b0, mc_reg} > ({1'b0, nom_reg[m]} + {1'b0, rej});
    assign eval = edge_seen | timeout;
    assign diff = (mc_reg >= nom_reg[m]) ? mc_reg - nom_reg[m] : nom_reg[m] - mc_reg;

    always_comb begin
      mc_next = eval ? 16'h0000 : ((mc_reg > 16'hFFFD) ? 16'hFFFF : mc_reg + 16'h0002);
      good_next = good_reg;
      fail_next = fail_reg;
      sts_next = sts_reg;
      if (eval) begin
        if (timeout || diff > rej) begin
          fail_next = (fail_reg == 8'hFF) ? fail_reg : fail_reg + 8'h01;
          good_next = 8'h00;
        end else if (diff <= acc) begin
          good_next = (good_reg == 8'hFF) ? good_reg : good_reg + 8'h01;
          fail_next = 8'h00;
        end
        // A zero threshold never fires, so a counter that is cleared cannot flip the status.
        // good threshold clears loss
        if (good_next == times_reg[m][7:0] && good_next != good_reg && |good_next) begin
          sts_next = 1'b0;
        end
        if (fail_next == times_reg[m][15:8] && fail_next != fail_reg && |fail_next) begin
          sts_next = 1'b1;
        end
      end
      evt_next = (evt_clr[m] && !sts_reg) ? 1'b0 : evt_reg;
      if (sts_next && !sts_reg) evt_next = 1'b1;
    end

    // counters and events clear, status invalid
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mc_reg <= 16'h0000;
        good_reg <= 8'h00;
        fail_reg <= 8'h00;
        sts_reg <= 1'b1;
        evt_reg <= 1'b0;
      end else if (clk_en_i) begin
        mc_reg <= mc_next;
        good_reg <= good_next;
        fail_reg <= fail_next;
        sts_reg <= sts_next;
        evt_reg <= evt_next;
      end
    end

    assign los_sts[m] = sts_reg;
    assign los_evt[m] = evt_reg;
  end

  assign los_status_o = los_sts;

endmodule

// File: dv/sorm_ref_model.sv
// Reference clock source for the two monitored reference inputs.
// Assumes the system clock paces it; a stopped reference rests low.
`timescale 1ns/100ps
module sorm_ref_model (
  // Clock and run control
  input wire logic ref_clk_i,
  input wire logic [1:0] run_i,
  // Reference clocks
  output logic [1:0] ref_o
);
  int cnt = 0;
  // Period of 20 cycles, far below the double rate.
  always @(posedge ref_clk_i) begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    ref_o <= run_i & (ref_o ^ {2{cnt == 9}});
  end
endmodule

// File: dv/sorm_ctrl_checker.sv
// Concurrent checks on the ports of sorm_ctrl.
// Assumes a single clock domain and a bind into every sorm_ctrl.
`timescale 1ns/100ps
module sorm_ctrl_checker (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic supplies_stable_i,
  input wire logic [8:0] feedback_ratio_whole_o,
  input wire logic [26:0] feedback_ratio_fraction_o,
  input wire logic [3:0] out_true_o,
  input wire logic [3:0] out_true_oe_o,
  input wire logic [3:0] out_comp_o,
  input wire logic [3:0] out_comp_oe_o,
  input wire logic [1:0] los_status_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Unused address stands in for no write, which keeps each property short.
  logic [11:0] wa;
  assign wa = (psel_i && penable_i && pwrite_i && clk_en_i) ? paddr_i : 12'hFFF;
  // Supplies are only a start-up condition, so later dips are not checked.
  logic supplies_seen;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supplies_seen <= 1'b0;
    end else if (supplies_stable_i) begin
      supplies_seen <= 1'b1;
    end
  end
  a_frac_write:
    assert property (wa == 12'h00C |=> feedback_ratio_fraction_o == $past(pwdata_i[26:0]))
    else $error("fraction not loaded");
  a_whole_write:
    assert property (wa == 12'h008 |=> feedback_ratio_whole_o == $past(pwdata_i[8:0]))
    else $error("whole part not loaded");
  a_pd_true:
    assert property (wa == 12'h014 && pwdata_i[7:4] == 4'hF |-> ##[1:4] out_true_oe_o == 4'h0)
    else $error("true pin still driven");
  a_pd_comp:
    assert property (wa == 12'h014 && pwdata_i[7:4] == 4'hF |-> ##[1:4] out_comp_oe_o == 4'h0)
    else $error("complement pin still driven");
  a_sync_pause:
    assert property (wa == 12'h000 && pwdata_i[3] |-> ##5 (out_true_o == 4'h0) [*8])
    else $error("outputs ran during sync");
  a_supply_hold:
    assert property (!supplies_seen |-> (out_true_oe_o | out_comp_oe_o) == 4'h0)
    else $error("driver on before supplies");
  a_reset_vals:
    assert property ($rose(reset_n_i) |-> los_status_o == 2'b11 && out_true_oe_o == 4'h0)
    else $error("bad state after reset");
  a_status_hold:
    assert property ($rose(reset_n_i) |=> (los_status_o == 2'b11) [*2])
    else $error("status left invalid too soon");
  cover property (wa == 12'h000 && pwdata_i[3]);
  cover property ($fell(los_status_o[0]));
  cover property ($rose(los_status_o[0]));
endmodule
bind sorm_ctrl sorm_ctrl_checker chk_i (.*);

// File: dv/sorm_ctrl_tb.sv
// Self-checking bench for sorm_ctrl: APB host, status pins, reference clocks.
// Assumes the package is compiled first and the reference model drives ref_in_i.
`timescale 1ns/100ps
module sorm_ctrl_tb
  import sorm_pkg::*;
;
  logic ref_clk_i = 0, reset_n_i = 0, clk_en_i = 1, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, supplies_stable_i = 0, bias_cal_done_i = 0, bias_cal_fail_i = 0;
  logic config_loaded_i = 0, pll_lock_i = 0, output_enable_pin_i = 0, pready_o, pslverr_o, qe;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, feedback_adjust_o, q;
  logic [26:0] feedback_ratio_fraction_o;
  logic [8:0] feedback_ratio_whole_o;
  logic [3:0] out_true_o, out_true_oe_o, out_comp_o, out_comp_oe_o;
  logic [1:0] los_status_o, ref_in_i, run = 0;
  int num_errors = 0, checks_done = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  sorm_ref_model refm (.ref_clk_i(ref_clk_i), .run_i(run), .ref_o(ref_in_i));
  sorm_ctrl #(.SYNC_CYCLES(20)) dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    qe = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic poll(input logic s, input logic [3:0] e);
    for (int i = 0; i < 400 && (s ? {2'b0, los_status_o} : out_true_oe_o) !== e; i++)
      @(posedge ref_clk_i);
    chk(s ? {2'b0, los_status_o} : out_true_oe_o, e);
  endtask
  task automatic state_is(input logic [2:0] s);
    for (int i = 0; i < 100 && q[10:8] !== s; i++)
      apb(1'b0, 12'h004, 0);
    chk(q[10:8], s);
  endtask
  task automatic t_start;
    apb(1'b0, 12'h0FC, 0);
    chk({q[30:0], qe}, 32'h0000_0001);
    apb(1'b0, 12'h01C, 0);
    chk(q, 32'h0404_0404);
    supplies_stable_i <= 1'b1;
    config_loaded_i <= 1'b1;
    bias_cal_done_i <= 1'b1;
    bias_cal_fail_i <= 1'b1;
    state_is(SORM_LOCKW);
    chk({out_true_oe_o, out_true_o | out_comp_o}, 8'hF0);
    pll_lock_i <= 1'b1;
    state_is(SORM_RUN);
    chk(q[2:0], 3'b111);
    pll_lock_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    apb(1'b0, 12'h004, 0);
    chk(q[3:2], 2'b10);
    apb(1'b1, 12'h004, 32'h0000_0008);
    apb(1'b0, 12'h004, 0);
    chk(q[3:2], 2'b00);
  endtask
  task automatic t_ratio;
    apb(1'b1, 12'h008, 32'h0000_0008);
    apb(1'b1, 12'h00C, 32'h0400_0000);
    apb(1'b1, 12'h010, 32'h0000_0003);
    apb(1'b1, 12'h000, 32'h0000_0004);
    chk(feedback_ratio_whole_o, 32'h0000_0008);
    chk(feedback_ratio_fraction_o, 32'h0400_0000);
    chk(feedback_adjust_o, 32'h0000_0003);
    apb(1'b1, 12'h000, 32'h0000_0005);
    apb(1'b0, 12'h000, 0);
    chk(feedback_adjust_o, 32'h0000_0019);
    clk_en_i <= 1'b0;
    fork
      apb(1'b1, 12'h010, 32'h0000_0001);
      begin
        repeat (6) @(posedge ref_clk_i);
        chk(feedback_adjust_o, 32'h0000_0019);
        clk_en_i <= 1'b1;
      end
    join
    repeat (2) @(posedge ref_clk_i);
    chk(feedback_adjust_o, 32'h0000_0008);
  endtask
  task automatic t_enable;
    logic [7:0] hi;
    logic [7:0] lo;
    apb(1'b1, 12'h000, 32'h0000_0004);
    apb(1'b1, 12'h018, 32'h0000_2222);
    poll(1'b0, 4'h0);
    output_enable_pin_i <= 1'b1;
    poll(1'b0, 4'hF);
    output_enable_pin_i <= 1'b0;
    poll(1'b0, 4'h0);
    output_enable_pin_i <= 1'b1;
    apb(1'b1, 12'h014, 32'h0000_0003);
    poll(1'b0, 4'hC);
    apb(1'b1, 12'h000, 32'h0000_0006);
    output_enable_pin_i <= 1'b0;
    apb(1'b1, 12'h014, 32'h0000_0005);
    poll(1'b0, 4'hA);
    apb(1'b1, 12'h018, 32'h0000_0000);
    poll(1'b0, 4'hF);
    chk((out_true_o | out_comp_o) & 4'h5, 4'h0);
    apb(1'b1, 12'h018, 32'h0000_8041);
    repeat (2) @(posedge ref_clk_i);
    hi = 8'h00;
    lo = 8'hFF;
    repeat (8) begin
      @(posedge ref_clk_i);
      hi = hi | {out_comp_o, out_true_o};
      lo = lo & {out_comp_o, out_true_o};
    end
    chk(hi, 8'h93);
    chk(lo, 8'h11);
    apb(1'b1, 12'h014, 32'h0000_00F0);
    repeat (20) @(posedge ref_clk_i);
    chk(out_true_oe_o | out_comp_oe_o, 4'h0);
    apb(1'b1, 12'h014, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_000E);
    apb(1'b0, 12'h004, 0);
    chk(q[10:8], SORM_RESYNC);
    state_is(SORM_RUN);
  endtask
  task automatic t_mon;
    for (int m = 0; m < 32; m += 16) begin
      apb(1'b1, 12'(32 + m), 32'h0000_0028);
      apb(1'b1, 12'(36 + m), 32'h0008_0004);
      apb(1'b1, 12'(40 + m), 32'h0000_0203);
    end
    run <= 2'b11;
    poll(1'b1, 4'h0);
    run <= 2'b10;
    poll(1'b1, 4'h1);
    apb(1'b1, 12'h004, 32'h0000_00C0);
    apb(1'b0, 12'h004, 0);
    chk(q[7:6], 2'b01);
    run <= 2'b11;
    poll(1'b1, 4'h0);
    apb(1'b1, 12'h004, 32'h0000_00C0);
    apb(1'b0, 12'h004, 0);
    chk(q[7:6], 2'b00);
  endtask
  task automatic test_done;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_start();
    t_ratio();
    t_enable();
    t_mon();
    test_done();
  end
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
